// ==== inc/srmc_map.svh ====
// register offsets, field positions, reset values and timing counts of the
// suspend/resume mode controller; assumes a 40 MHz suspend-well clock
`ifndef SRMC_MAP_SVH
`define SRMC_MAP_SVH

// clock and timing
`define SRMC_CLK_HZ        40000000
`define SRMC_SLOW_REFRESH_CLOCK_OUT_HZ     32000
`define SRMC_SLOW_REFRESH_CLOCK_OUT_HALF   (`SRMC_CLK_HZ / (2 * `SRMC_SLOW_REFRESH_CLOCK_OUT_HZ))
`define SRMC_PLL_WAIT_MS   20
`define SRMC_PLL_WAIT_CYC  (`SRMC_CLK_HZ / 1000 * `SRMC_PLL_WAIT_MS)
`define SRMC_STEP_US       1
`define SRMC_STEP_CYC      (`SRMC_CLK_HZ / 1000000 * `SRMC_STEP_US)
`define SRMC_RST_US        100
`define SRMC_RST_CYC       (`SRMC_CLK_HZ / 1000000 * `SRMC_RST_US)

// register byte offsets
`define SRMC_OFS_CTRL      8'h00
`define SRMC_OFS_WAKE_EN   8'h04
`define SRMC_OFS_STATUS    8'h08
`define SRMC_OFS_MASK      8'h0C
`define SRMC_OFS_STATE     8'h10

// control register fields
`define SRMC_CTRL_TYPE_LSB 0
`define SRMC_CTRL_EN_BIT   2
`define SRMC_CTRL_RSM_LSB  4

// output level codes {bridge, peripheral, plane one, two, three}
`define SRMC_LV_ON         5'h1F
`define SRMC_LV_STAT       5'h07
`define SRMC_LV_ONE        5'h03
`define SRMC_LV_TWO        5'h01
`define SRMC_LV_THREE      5'h00

// reset values
`define SRMC_RST_CTRL      6'h00
`define SRMC_RST_WORD      32'h0000_0000

`endif

// ==== inc/srmc_pkg.sv ====
// types shared by the suspend/resume mode controller files
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package srmc_pkg;
    typedef enum logic [3:0] {
        SRMC_ON, SRMC_ENT_STAT, SRMC_ENT_ONE, SRMC_ENT_TWO, SRMC_ENT_THREE,
        SRMC_STBY, SRMC_RAM, SRMC_DISK,
        SRMC_RES_THREE, SRMC_RES_TWO, SRMC_RES_ONE, SRMC_RES_RST, SRMC_RES_PLL
    } srmc_state_e;

    typedef enum logic [1:0] {SRMC_SUS_STBY, SRMC_SUS_RAM, SRMC_SUS_DISK} srmc_sus_e;
    typedef enum logic [1:0] {SRMC_RSM_NONE, SRMC_RSM_CPU, SRMC_RSM_SYS} srmc_rsm_e;
endpackage : srmc_pkg
`default_nettype wire

// ==== logic/srmc_clkdiv.sv ====
// 32 kHz slow refresh clock generator
// assumes a 40 MHz clk_sys; output held low while run is low
`default_nettype none
`include "srmc_map.svh"
module srmc_clkdiv #(
    parameter int HALF = `SRMC_SLOW_REFRESH_CLOCK_OUT_HALF
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // control
    input  wire logic run,
    // clock out
    output logic      clk_out
);
    import srmc_pkg::*;

    logic [11:0] cnt_q, cnt_d;
    logic        clk_q, clk_d;

    always_comb begin
        cnt_d = '0;
        clk_d = 1'b0;
        if (run) begin
            if (cnt_q == 12'(HALF - 1)) begin
                clk_d = ~clk_q;
            end else begin
                cnt_d = cnt_q + 12'h001;
                clk_d = clk_q;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
            clk_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            clk_q <= clk_d;
        end
    end

    assign clk_out = clk_q;
endmodule // srmc_clkdiv
`default_nettype wire

// ==== logic/srmc_top.sv ====
// suspend/resume mode controller with Avalon-MM register slave
// assumes a 40 MHz suspend-well clock and asynchronous resume reset
// Notes on behaviour
// RQ1: full-on plus standby, RAM and disk suspend
// RQ2: standby drops plane one to stop synthesizer
// RQ3: slow refresh clock runs during standby
// RQ4: standby resume: no, processor or system reset
// RQ5: no-reset resume waits for PLL lock
// RQ6: RAM suspend drops plane two, clock runs
// RQ7: RAM resume always ends in system reset
// RQ8: disk suspend drops plane three; system reset
// RQ9: any suspend mode accepted from full-on
// RQ10: several enabled wake sources each resume
// RQ11: fixed output levels in every state
// RQ12: software writes type, then enable bit
// RQ13: wake sets status, steps outputs to full-on
// RQ14: one state, planes change one step
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`default_nettype none
`include "srmc_map.svh"
module srmc_top #(
    parameter int NWAKE        = 8,
    parameter int PLL_WAIT_CYC = `SRMC_PLL_WAIT_CYC
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    // wake sources, asynchronous, active high
    input  wire logic [NWAKE-1:0] wake_req,
    // suspend outputs
    output logic             bridge_suspend_status_n,
    output logic             peripheral_suspend_status_n,
    output logic             plane_one_off_n,
    output logic             plane_two_off_n,
    output logic             plane_three_off_n,
    output logic             slow_refresh_clock_out,
    output logic             cpu_reset_out,
    output logic             sys_reset_out
);
    import srmc_pkg::*;

    localparam int CNT_W = 20;

    function automatic logic [4:0] srmc_levels(input srmc_state_e s);
        case (s)
            SRMC_ON:                               srmc_levels = `SRMC_LV_ON;
            SRMC_ENT_STAT, SRMC_RES_ONE,
            SRMC_RES_RST, SRMC_RES_PLL:            srmc_levels = `SRMC_LV_STAT;
            SRMC_ENT_ONE, SRMC_STBY, SRMC_RES_TWO: srmc_levels = `SRMC_LV_ONE;
            SRMC_ENT_TWO, SRMC_RAM, SRMC_RES_THREE: srmc_levels = `SRMC_LV_TWO;
            default:                               srmc_levels = `SRMC_LV_THREE;
        endcase
    endfunction

    function automatic logic [31:0] srmc_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
        end
        return r;
    endfunction

    // wake input synchronisers
    logic [NWAKE-1:0] wk_s1_q, wk_s2_q, wk_s3_q;
    logic [NWAKE-1:0] wake_rise;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wk_s1_q <= '0;
            wk_s2_q <= '0;
            wk_s3_q <= '0;
        end else begin
            wk_s1_q <= wake_req;
            wk_s2_q <= wk_s1_q;
            wk_s3_q <= wk_s2_q;
        end
    end
    assign wake_rise = wk_s2_q & ~wk_s3_q;

    // register and bus state
    logic             wait_q, wait_d;
    logic [31:0]      rd_q, rd_d;
    logic [5:0]       ctrl_q, ctrl_d;
    logic [NWAKE-1:0] wen_q, wen_d;
    logic [NWAKE:0]   stat_q, stat_d, mask_q, mask_d;
    logic             irq_q, irq_d;
    logic             wr_go, start, done_ev;
    logic [NWAKE-1:0] hit;
    logic [31:0]      ctrl_w, wen_w, stat_w, mask_w;

    // sequencer state
    srmc_state_e      state_q, state_d;
    srmc_sus_e        tgt_q, tgt_d;
    srmc_rsm_e        rsm_q, rsm_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             pend_q, pend_d;
    logic [4:0]       lv_q, lv_d;
    logic             cpu_q, cpu_d, sys_q, sys_d;

    assign wr_go  = avs_write & ~wait_q;
    assign hit    = wake_rise & wen_q;
    assign ctrl_w = srmc_merge({26'h0, ctrl_q}, avs_writedata, avs_byteenable);
    assign wen_w  = srmc_merge(32'(wen_q), avs_writedata, avs_byteenable);
    assign stat_w = srmc_merge(`SRMC_RST_WORD, avs_writedata, avs_byteenable);
    assign mask_w = srmc_merge(32'(mask_q), avs_writedata, avs_byteenable);
    // suspend entry accepted only from full-on with a valid type
    assign start  = wr_go && avs_address == `SRMC_OFS_CTRL && state_q == SRMC_ON // RQ12
                    && ctrl_w[`SRMC_CTRL_EN_BIT] && ctrl_w[`SRMC_CTRL_TYPE_LSB +: 2] != 2'h3;

    always_comb begin
        wait_d = ~((avs_read | avs_write) & wait_q);
        rd_d   = rd_q;
        ctrl_d = ctrl_q;
        wen_d  = wen_q;
        mask_d = mask_q;
        stat_d = stat_q;
        if ((avs_read | avs_write) & wait_q) begin
            case (avs_address)
                `SRMC_OFS_CTRL:    rd_d = {26'h0, ctrl_q};
                `SRMC_OFS_WAKE_EN: rd_d = 32'(wen_q);
                `SRMC_OFS_STATUS:  rd_d = 32'(stat_q);
                `SRMC_OFS_MASK:    rd_d = 32'(mask_q);
                `SRMC_OFS_STATE:   rd_d = {28'h0, state_q};
                default:           rd_d = `SRMC_RST_WORD;
            endcase
        end
        if (wr_go) begin
            case (avs_address)
                `SRMC_OFS_CTRL:    ctrl_d = ctrl_w[5:0] & 6'h33;
                `SRMC_OFS_WAKE_EN: wen_d  = wen_w[NWAKE-1:0];
                `SRMC_OFS_STATUS:  stat_d = stat_q & ~stat_w[NWAKE:0];
                `SRMC_OFS_MASK:    mask_d = mask_w[NWAKE:0];
                default:           ;
            endcase
        end
        // set wins over a simultaneous clear
        stat_d = stat_d | {done_ev, hit}; // RQ13
        irq_d  = |(stat_d & mask_d);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wait_q <= 1'b1;
            rd_q   <= `SRMC_RST_WORD;
            ctrl_q <= `SRMC_RST_CTRL;
            wen_q  <= '0;
            stat_q <= '0;
            mask_q <= '0;
            irq_q  <= 1'b0;
        end else begin
            wait_q <= wait_d;
            rd_q   <= rd_d;
            ctrl_q <= ctrl_d;
            wen_q  <= wen_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q  <= irq_d;
        end
    end

    // power state sequencer
    always_comb begin
        state_d = state_q;
        tgt_d   = tgt_q;
        rsm_d   = rsm_q;
        cnt_d   = (cnt_q == '0) ? cnt_q : cnt_q - 1'b1;
        pend_d  = pend_q | ((|hit) & (state_q != SRMC_ON)); // RQ10
        done_ev = 1'b0;
        case (state_q)
            SRMC_ON: begin
                pend_d = 1'b0;
                if (start) begin // RQ9
                    state_d = SRMC_ENT_STAT;
                    tgt_d   = srmc_sus_e'(ctrl_w[`SRMC_CTRL_TYPE_LSB +: 2]); // RQ1
                    rsm_d   = (ctrl_w[`SRMC_CTRL_RSM_LSB +: 2] == 2'h0) ? SRMC_RSM_NONE :
                              (ctrl_w[`SRMC_CTRL_RSM_LSB +: 2] == 2'h1) ? SRMC_RSM_CPU :
                              SRMC_RSM_SYS;
                    cnt_d   = CNT_W'(`SRMC_STEP_CYC);
                end
            end
            SRMC_ENT_STAT: if (cnt_q == '0) begin
                state_d = SRMC_ENT_ONE; // RQ2
                cnt_d   = CNT_W'(`SRMC_STEP_CYC);
            end
            SRMC_ENT_ONE: if (cnt_q == '0) begin
                state_d = (tgt_q == SRMC_SUS_STBY) ? SRMC_STBY : SRMC_ENT_TWO; // RQ14
                cnt_d   = CNT_W'(`SRMC_STEP_CYC);
            end
            SRMC_ENT_TWO: if (cnt_q == '0) begin
                state_d = (tgt_q == SRMC_SUS_RAM) ? SRMC_RAM : SRMC_ENT_THREE; // RQ6
                cnt_d   = CNT_W'(`SRMC_STEP_CYC);
            end
            SRMC_ENT_THREE: if (cnt_q == '0) state_d = SRMC_DISK; // RQ8
            SRMC_STBY, SRMC_RAM, SRMC_DISK: if (pend_q) begin // RQ13
                pend_d  = 1'b0;
                state_d = (state_q == SRMC_STBY) ? SRMC_RES_ONE :
                          (state_q == SRMC_RAM) ? SRMC_RES_TWO : SRMC_RES_THREE;
                cnt_d   = CNT_W'(`SRMC_STEP_CYC);
            end
            SRMC_RES_THREE: if (cnt_q == '0) begin
                state_d = SRMC_RES_TWO;
                cnt_d   = CNT_W'(`SRMC_STEP_CYC);
            end
            SRMC_RES_TWO: if (cnt_q == '0) begin
                state_d = SRMC_RES_ONE;
                cnt_d   = CNT_W'(`SRMC_STEP_CYC);
            end
            SRMC_RES_ONE: if (cnt_q == '0) begin
                if (tgt_q == SRMC_SUS_STBY && rsm_q == SRMC_RSM_NONE) begin
                    state_d = SRMC_RES_PLL; // RQ5
                    cnt_d   = CNT_W'(PLL_WAIT_CYC);
                end else begin
                    state_d = SRMC_RES_RST; // RQ4 RQ7 RQ8
                    cnt_d   = CNT_W'(`SRMC_RST_CYC);
                end
            end
            SRMC_RES_RST, SRMC_RES_PLL: if (cnt_q == '0) begin
                state_d = SRMC_ON;
                done_ev = 1'b1;
            end
            default: state_d = SRMC_ON;
        endcase
        lv_d  = srmc_levels(state_d); // RQ11
        sys_d = (state_d == SRMC_RES_RST) && (tgt_q != SRMC_SUS_STBY || rsm_q == SRMC_RSM_SYS);
        cpu_d = (state_d == SRMC_RES_RST) && !sys_d; // RQ4
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= SRMC_ON;
            tgt_q   <= SRMC_SUS_STBY;
            rsm_q   <= SRMC_RSM_NONE;
            cnt_q   <= '0;
            pend_q  <= 1'b0;
            lv_q    <= `SRMC_LV_ON;
            cpu_q   <= 1'b0;
            sys_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            tgt_q   <= tgt_d;
            rsm_q   <= rsm_d;
            cnt_q   <= cnt_d;
            pend_q  <= pend_d;
            lv_q    <= lv_d;
            cpu_q   <= cpu_d;
            sys_q   <= sys_d;
        end
    end

    // refresh clock runs while plane one is off and plane three is on
    srmc_clkdiv #(.HALF(`SRMC_SLOW_REFRESH_CLOCK_OUT_HALF)) u_clkdiv (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .run     (~lv_q[2] & lv_q[0]), // RQ3 RQ6
        .clk_out (slow_refresh_clock_out)
    );

    assign avs_readdata                = rd_q;
    assign avs_waitrequest             = wait_q;
    assign irq                         = irq_q;
    assign bridge_suspend_status_n     = lv_q[4];
    assign peripheral_suspend_status_n = lv_q[3];
    assign plane_one_off_n             = lv_q[2];
    assign plane_two_off_n             = lv_q[1];
    assign plane_three_off_n           = lv_q[0];
    assign cpu_reset_out               = cpu_q;
    assign sys_reset_out               = sys_q;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    logic [CNT_W-1:0] pll_cyc_q;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) pll_cyc_q <= '0;
        else pll_cyc_q <= (state_q == SRMC_RES_PLL) ? pll_cyc_q + 1'b1 : '0;
    end

    on_levels_a: assert property ((state_q == SRMC_ON) |-> lv_q == 5'h1F) // RQ11
        else $error("full-on levels wrong");
    stby_levels_a: assert property ((state_q == SRMC_STBY) |-> // RQ2
        !bridge_suspend_status_n && !peripheral_suspend_status_n && !plane_one_off_n
        && plane_two_off_n && plane_three_off_n) else $error("standby levels wrong");
    ram_levels_a: assert property ((state_q == SRMC_RAM) |-> // RQ6
        !plane_one_off_n && !plane_two_off_n && plane_three_off_n)
        else $error("RAM levels wrong");
    disk_levels_a: assert property ((state_q == SRMC_DISK) |-> lv_q == 5'h00) // RQ8
        else $error("disk levels wrong");
    plane_step_a: assert property ($countones(lv_q[2:0] ^ $past(lv_q[2:0])) <= 1) // RQ14
        else $error("two planes moved at once");
    refresh_clk_a: assert property ((state_q == SRMC_STBY) |-> // RQ3
        ##[1:700] ($changed(slow_refresh_clock_out) || state_q != SRMC_STBY))
        else $error("refresh clock stalled");
    ram_reset_a: assert property ((state_q == SRMC_RAM && pend_q) |-> // RQ7
        ##[1:200] sys_reset_out) else $error("no system reset after RAM");
    pll_wait_a: assert property ((state_q == SRMC_RES_PLL && state_d == SRMC_ON) |-> // RQ5
        pll_cyc_q == CNT_W'(PLL_WAIT_CYC)) else $error("PLL wait length wrong");
    wake_stat_a: assert property ((|hit) |=> // RQ13
        ((stat_q[NWAKE-1:0] & $past(hit)) == $past(hit))) else $error("wake not latched");
    irq_level_a: assert property (irq == $past(|(stat_d & mask_d)))
        else $error("interrupt level wrong");

    stby_cycle_c: cover property ((state_q == SRMC_STBY) ##[1:300] (state_q == SRMC_ON));
    ram_cycle_c: cover property ((state_q == SRMC_RAM) ##[1:300] sys_reset_out);
    disk_cycle_c: cover property ((state_q == SRMC_DISK) ##[1:300] (state_q == SRMC_RES_RST));
    cpu_reset_c: cover property ($rose(cpu_reset_out));
endmodule // srmc_top
`default_nettype wire

// ==== verification/srmc_far_model.sv ====
// far side of the controller: wake sources and the clock synthesizer
// assumes the bench asks for one wake pulse at a time
`default_nettype none
module srmc_far_model (
    // clock
    input  wire logic       clk_sys,
    // bench command
    input  wire logic       fire,
    input  wire logic [2:0] idx,
    // far-side lines
    input  wire logic       plane_one_off_n,
    output logic      [7:0] wake_req,
    output logic            synth_run
);
    timeunit 1ns;
    timeprecision 1ps;
    int hold;
    initial begin
        wake_req = 8'h00;
        hold = 0;
    end
    // synthesizer stops while its plane is off
    assign synth_run = plane_one_off_n;
    // wake line held a few cycles so the synchronizer sees it
    always @(posedge clk_sys) begin
        if (fire) begin
            wake_req[idx] <= 1'b1;
            hold <= 6;
        end else if (hold > 0) begin
            hold <= hold - 1;
            if (hold == 1) wake_req <= 8'h00;
        end
    end
endmodule // srmc_far_model
`default_nettype wire

// ==== verification/suspend_resume_mode_control_bench.sv ====
// self-checking bench for the suspend/resume mode controller
// assumes srmc_far_model and the register map header
`default_nettype none
`include "srmc_map.svh"
module suspend_resume_mode_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [1:0] typ;
        logic [1:0] rsm;
        logic [4:0] lv;
        int         ncpu;
        int         nsys;
        logic       clk;
    } srmc_row_s;
    localparam int RST = `SRMC_RST_CYC + 1;
    logic        clk_sys, reset_n, avs_read, avs_write, avs_waitrequest, irq, fire;
    logic [7:0]  avs_address, wake_req;
    logic [31:0] avs_writedata, avs_readdata, rd_s, q;
    logic [3:0]  avs_byteenable, be_s;
    logic [2:0]  idx;
    logic        b_n, p_n, one_n, two_n, three_n, slow_clk, cpu_rst, sys_rst;
    logic        wq_s, clk_prev, synth_on;
    logic [4:0]  lv;
    int          error_cnt, n_compared, n_cpu, n_sys, n_tog, cyc;
    srmc_row_s   rows [6];
    assign lv = {b_n, p_n, one_n, two_n, three_n};

    srmc_top #(.NWAKE(8), .PLL_WAIT_CYC(50)) dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .wake_req(wake_req),
        .bridge_suspend_status_n(b_n), .peripheral_suspend_status_n(p_n),
        .plane_one_off_n(one_n), .plane_two_off_n(two_n), .plane_three_off_n(three_n),
        .slow_refresh_clock_out(slow_clk), .cpu_reset_out(cpu_rst), .sys_reset_out(sys_rst)
    );
    srmc_far_model far_u (
        .clk_sys(clk_sys), .fire(fire), .idx(idx), .plane_one_off_n(one_n),
        .wake_req(wake_req), .synth_run(synth_on)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // settled values, taken between edges
    always @(negedge clk_sys) begin
        wq_s = avs_waitrequest;
        rd_s = avs_readdata;
        if (slow_clk !== clk_prev) n_tog++;
        clk_prev = slow_clk;
        if (cpu_rst === 1'b1) n_cpu++;
        if (sys_rst === 1'b1) n_sys++;
        if (reset_n && !(lv inside {5'h1F, 5'h07, 5'h03, 5'h01, 5'h00})) begin
            error_cnt++;
            $display("[ERR] level step expected a legal step seen %h", lv);
        end
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 45000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be_s;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do @(posedge clk_sys); while (wq_s !== 1'b0);
        q = rd_s;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic wait_state(input logic [3:0] code);
        for (int i = 0; i < 3000; i++) begin
            bus(1'b0, `SRMC_OFS_STATE, 32'h0);
            if (q[3:0] === code) break;
        end
    endtask
    task automatic pulse_wake(input logic [2:0] w);
        @(posedge clk_sys);
        idx <= w;
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        rows = '{'{2'h0, 2'h0, `SRMC_LV_ONE, 0, 0, 1'b1},
                 '{2'h1, 2'h0, `SRMC_LV_TWO, 0, RST, 1'b1},
                 '{2'h2, 2'h0, `SRMC_LV_THREE, 0, RST, 1'b0},
                 '{2'h0, 2'h1, `SRMC_LV_ONE, RST, 0, 1'b1},
                 '{2'h0, 2'h2, `SRMC_LV_ONE, 0, RST, 1'b1},
                 '{2'h0, 2'h3, `SRMC_LV_ONE, 0, RST, 1'b1}};
        {avs_read, avs_write, fire, clk_prev} = 4'h0;
        {avs_address, avs_writedata, avs_byteenable, idx} = 47'h0;
        be_s = 4'hF;
        reset_n = 1'b0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(negedge clk_sys);
        chk("levels after reset", `SRMC_LV_ON, lv);
        chk("waitrequest idle", 32'h1, avs_waitrequest);
        chk("irq after reset", 32'h0, irq);
        for (int a = 0; a < 5; a++) rd(8'(4 * a), `SRMC_RST_WORD, "register reset value");
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, `SRMC_OFS_WAKE_EN, 32'h0000_00FF);
            bus(1'b1, `SRMC_OFS_MASK, 32'h0000_0100);
            n_cpu = 0;
            n_sys = 0;
            bus(1'b1, `SRMC_OFS_CTRL, {26'h0, rows[i].rsm, 2'h1, rows[i].typ});
            wait_state(4'h5 + 4'(rows[i].typ));
            chk("suspend levels", rows[i].lv, lv);
            chk("synthesizer stopped", 32'h0, synth_on);
            n_tog = 0;
            repeat (1300) @(posedge clk_sys);
            chk("refresh clock running", rows[i].clk, n_tog >= 2);
            pulse_wake(3'(i));
            wait_state(4'h0);
            chk("levels after resume", `SRMC_LV_ON, lv);
            chk("synthesizer running", 32'h1, synth_on);
            chk("refresh clock stopped", 32'h0, slow_clk);
            chk("processor reset cycles", rows[i].ncpu, n_cpu);
            chk("system reset cycles", rows[i].nsys, n_sys);
            rd(`SRMC_OFS_STATUS, 32'h100 | (32'h1 << i), "wake status");
            chk("irq raised", 32'h1, irq);
            bus(1'b1, `SRMC_OFS_STATUS, 32'h0000_01FF);
            rd(`SRMC_OFS_STATUS, 32'h0, "status cleared");
            chk("irq dropped", 32'h0, irq);
        end
        bus(1'b1, `SRMC_OFS_MASK, 32'h0);
        be_s = 4'h2;
        bus(1'b1, `SRMC_OFS_MASK, 32'h0000_01FF);
        be_s = 4'hF;
        rd(`SRMC_OFS_MASK, 32'h0000_0100, "byte lane write");
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0, "unmapped read");
        bus(1'b1, `SRMC_OFS_STATE, 32'h0000_0005);
        rd(`SRMC_OFS_STATE, 32'h0, "state read only");
        bus(1'b1, `SRMC_OFS_CTRL, 32'h0000_0007);
        rd(`SRMC_OFS_STATE, 32'h0, "reserved type refused");
        rd(`SRMC_OFS_CTRL, 32'h3, "start bit reads zero");
        bus(1'b1, `SRMC_OFS_CTRL, 32'h0000_0004);
        repeat (60) @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(negedge clk_sys);
        chk("levels after second reset", `SRMC_LV_ON, lv);
        rd(`SRMC_OFS_STATE, 32'h0, "state after second reset");
        pulse_wake(3'h2);
        repeat (10) @(posedge clk_sys);
        rd(`SRMC_OFS_STATUS, 32'h0, "disabled wake ignored");
        report_and_stop();
    end
endmodule // suspend_resume_mode_control_bench
`default_nettype wire
